// ===== dv/flfc_stage.sv
// Behavioural power stage: primary current ramp and aux sense bias
`timescale 1ns/1ps
`default_nettype none

module flfc_stage (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic gate_i,
  input wire logic slow_i,
  input wire logic sense_req_i,
  input wire logic on_bias_i,
  output logic cs_peak_o,
  output logic cs_latch_o
);
  // Clocks of on time since the switch turned on
  logic [10:0] ramp_q;

  // Ramp restarts at every turn-off
  always_ff @(posedge clk_i) begin
    if (rst_i || !gate_i) begin
      ramp_q <= 11'h000;
    end else begin
      ramp_q <= ramp_q + 11'h001;
    end
  end

  // Slow ramp mimics a large inductance, still inside the on window
  assign cs_peak_o = gate_i && (ramp_q >= (slow_i ? 11'h258 : 11'h064));
  // Aux winding is positive only off time; on-bias models a Zener fault
  assign cs_latch_o = sense_req_i && (on_bias_i ? gate_i : !gate_i);
endmodule

`default_nettype wire

// ===== dv/flfc_top_bench.sv
// Self-checking bench for the fault latch and foldback controller
`timescale 1ns/1ps
`default_nettype none

module flfc_top_bench;
  localparam int FC = 20000; // Shortened fault timer
  localparam int P = 1924; // Clocks per switching cycle at 65 kHz
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [11:0] fb = 12'h7D0;
  logic peak = 1'h0, uv = 1'h0, von = 1'h0, vrst = 1'h0, bo = 1'h0;
  logic req = 1'h0, bias = 1'h0, slow = 1'h0;
  logic ack, gate, skip, latched, err, cs_peak, cs_latch;
  logic [6:0] freq;
  logic [9:0] spt;
  int n_fail = 0;
  int num_checks = 0;
  int tbl[13] = '{3000, 2400, 2000, 1500, 1350, 1201, 1200, 1000, 750,
                  700, 600, 599, 500};

  // Free-running 125 MHz clock
  always #4 clk_i = ~clk_i;

  flfc_top #(.FAULT_CYCLES(FC)) u_flfc_top (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fb_mv_i(fb), .cs_peak_i(cs_peak), .peak_max_i(peak),
    .cs_latch_i(cs_latch), .supply_undervoltage_lockout_i(uv),
    .vcc_on_i(von), .vcc_reset_i(vrst), .brown_out_input_i(bo),
    .gate_o(gate), .freq_khz_o(freq), .setpoint_mv_o(spt), .skip_o(skip),
    .latched_o(latched), .err_flag_o(err));

  flfc_stage u_flfc_stage (.clk_i(clk_i), .rst_i(rst_i), .gate_i(gate),
    .slow_i(slow), .sense_req_i(req), .on_bias_i(bias),
    .cs_peak_o(cs_peak), .cs_latch_o(cs_latch));

  // Compare one result and count it
  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  // Classic single cycle; request held until ack is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  // Register read compared under a mask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
          input string what);
    bus(1'h0, a, 32'h0);
    check(what, e, q & m);
  endtask

  // Edge events: 0 turn-on, 1 undervoltage, 2 peak, 3 brown-out, 4 reset
  task ev(input int k);
    @(posedge clk_i);
    case (k)
      0: von <= 1'h1;
      1: uv <= 1'h1;
      2: peak <= 1'h1;
      3: bo <= 1'h1;
      default: vrst <= 1'h1;
    endcase
    repeat (3) @(posedge clk_i);
    {von, uv, peak, bo, vrst} <= 5'h00;
    repeat (3) @(posedge clk_i);
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Gate must stay low for the whole span
  task quiet(input int n);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (gate !== 1'h0) c++;
    end
    check("gate pulses", 32'h0, c);
  endtask

  // Expected loop word: skip, setpoint and frequency from feedback
  function automatic logic [31:0] loop_exp(input int f);
    int fr, sp;
    fr = f >= 1500 ? 65 : f <= 1200 ? 26 : 26 + (f - 1200) * 39 / 300;
    sp = f >= 2400 ? 800 : f <= 750 ? 250 : f / 3;
    return (32'(f < 600) << 26) | (32'(sp) << 16) | 32'(fr);
  endfunction

  // Single place where the run ends
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard, a little beyond the expected run length
  initial begin
    tick(100000);
    n_fail++;
    $display("test watchdog expired");
    conclude();
  end

  // Main sequence
  initial begin
    tick(10);
    rst_i <= 1'h0;
    check("loop ports", 32'h0320_0041, {5'h0, skip, spt, 9'h0, freq});
    check("flags", 32'h0, {gate, latched, err});
    rd(8'h00, 32'hFF, 32'h3, "ctrl");
    bus(1'h1, 8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'hFF, 32'h10, "stat");
    bus(1'h1, 8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'hFFFF_FFFF, 32'h0, "unmapped");
    rd(8'h08, 32'hFFFF_FFFF, loop_exp(2000), "loop");
    $display("test reset done");
    // Sustained overload until the timer runs out
    ev(0);
    rd(8'h04, 32'h7, 32'h1, "state");
    peak <= 1'h1;
    tick(3);
    check("err flag", 32'h1, err);
    tick(FC - 60);
    check("latched", 32'h0, latched);
    tick(80);
    check("latched", 32'h1, latched);
    peak <= 1'h0;
    ev(0);
    ev(0);
    quiet(2 * P);
    check("latched", 32'h1, latched);
    ev(4);
    check("latched", 32'h0, latched);
    rd(8'h04, 32'h7, 32'h0, "state");
    ev(0);
    rd(8'h04, 32'h7, 32'h1, "state");
    $display("test timer latch done");
    // Undervoltage while the flag is up
    ev(2);
    ev(1);
    check("latched", 32'h1, latched);
    ev(3);
    check("latched", 32'h0, latched);
    rd(8'h04, 32'h1F, 32'h10, "stat");
    $display("test pre-short done");
    // Regulation disarms, then double hiccup
    ev(0);
    ev(2);
    tick(9 * P + 500);
    check("err flag", 32'h0, err);
    rd(8'h04, 32'h18, 32'h0, "stat");
    ev(1);
    rd(8'h04, 32'h1F, 32'h12, "stat");
    check("latched", 32'h0, latched);
    ev(0);
    rd(8'h04, 32'h7, 32'h3, "state");
    ev(0);
    rd(8'h04, 32'h7, 32'h1, "state");
    $display("test hiccup done");
    // Auto-recovery option never arms
    bus(1'h1, 8'h00, 32'h2);
    ev(3);
    rd(8'h04, 32'h1F, 32'h0, "stat");
    ev(0);
    ev(2);
    ev(1);
    rd(8'h04, 32'h7, 32'h2, "state");
    ev(0);
    ev(0);
    $display("test auto option done");
    // Foldback, setpoint and skip table
    foreach (tbl[i]) begin
      fb <= 12'(tbl[i]);
      tick(4);
      check("loop ports", loop_exp(tbl[i]),
            {5'h0, skip, spt, 9'h0, freq});
    end
    quiet(3 * P);
    fb <= 12'h7D0;
    tick(4);
    $display("test foldback done");
    // Sense latch: on-time bias, short burst, long burst
    slow <= 1'h1;
    bias <= 1'h1;
    req <= 1'h1;
    tick(6 * P);
    check("latched", 32'h0, latched);
    bias <= 1'h0;
    tick(4 * P - 200);
    req <= 1'h0;
    tick(P);
    check("latched", 32'h0, latched);
    rd(8'h04, 32'hE0, 32'h0, "count");
    req <= 1'h1;
    tick(6 * P + 100);
    check("latched", 32'h1, latched);
    req <= 1'h0;
    ev(3);
    check("latched", 32'h0, latched);
    $display("test sense latch done");
    conclude();
  end
endmodule

`default_nettype wire

// ===== rtl/flfc_consts.svh
// Named constants for the fault latch and foldback controller
`ifndef FLFC_CONSTS_SVH
`define FLFC_CONSTS_SVH

// Clock rate and fault timer
`define FLFC_CLK_MHZ 125
`define FLFC_FAULT_US 70000

// Feedback thresholds in mV
`define FLFC_FB_FOLD_HI 12'h5DC
`define FLFC_FB_FOLD_LO 12'h4B0
`define FLFC_FB_IPK_HI 12'h960
`define FLFC_FB_IPK_LO 12'h2EE
`define FLFC_FB_SKIP 12'h258

// Switching frequency in kHz, foldback width in mV
`define FLFC_F_NOM 7'h41
`define FLFC_F_MIN 7'h1A
`define FLFC_F_SPAN 16'h0027
`define FLFC_FOLD_WIDTH 16'h012C

// Peak current setpoint in mV
`define FLFC_IPK_MAX 10'h320
`define FLFC_IPK_MIN 10'h0FA
`define FLFC_IPK_DIV 12'h003

// Phase accumulator: clock kHz, on-time end, late off-time sample
`define FLFC_ACC_WRAP 17'h1E848
`define FLFC_ACC_HALF 17'h0F424
`define FLFC_ACC_LATE 17'h1AB3F

// Cycle counts
`define FLFC_REG_CYCLES 4'h8
`define FLFC_CS_CONSEC 3'h4

// Register byte addresses
`define FLFC_ADR_CTRL 8'h00
`define FLFC_ADR_STAT 8'h04
`define FLFC_ADR_LOOP 8'h08

// Control fields and reset value
`define FLFC_CTRL_LATCH 0
`define FLFC_CTRL_EN 1
`define FLFC_CTRL_RST 2'h3

`endif

// ===== rtl/flfc_osc.sv
// Switching oscillator built on a phase accumulator
`timescale 1ns/1ps
`default_nettype none
`include "flfc_consts.svh"

module flfc_osc (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] freq_khz_i,
  output logic cyc_o,
  output logic on_o,
  output logic late_o
);

  // Phase in kHz-clock units, wraps once per switching cycle
  logic [16:0] acc_q;
  logic [16:0] acc_d;
  logic [17:0] sum;

  // Advance by the frequency; no divider needed for any rate
  always_comb begin
    sum = {1'b0, acc_q} + {11'h000, freq_khz_i};
    if (sum >= {1'b0, `FLFC_ACC_WRAP}) begin
      acc_d = 17'(sum - {1'b0, `FLFC_ACC_WRAP});
    end else begin
      acc_d = sum[16:0];
    end
  end

  // Phase register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= 17'h00000;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Cycle start pulse when the phase wraps
  assign cyc_o = (acc_d < acc_q);
  // First half of the cycle may carry the on pulse
  assign on_o = (acc_q < `FLFC_ACC_HALF);
  // Late off-time pulse: phase crosses seven eighths
  assign late_o = (acc_q < `FLFC_ACC_LATE) && (acc_d >= `FLFC_ACC_LATE)
                  && !cyc_o;

endmodule
`default_nettype wire

// ===== rtl/flfc_pkg.sv
// Types shared by the fault latch and foldback controller
package flfc_pkg;

  // Supervisor states
  typedef enum logic [2:0] {
    FLFC_START = 3'b000,
    FLFC_RUN   = 3'b001,
    FLFC_HIC1  = 3'b010,
    FLFC_HIC2  = 3'b011,
    FLFC_LATCH = 3'b100
  } flfc_state_t;

endpackage

// ===== rtl/flfc_top.sv
// Fault supervision, foldback and skip control with Wishbone registers
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "flfc_consts.svh"

module flfc_top #(
  parameter int unsigned FAULT_CYCLES = `FLFC_FAULT_US * `FLFC_CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Power stage sensing
  input wire logic [11:0] fb_mv_i,
  input wire logic cs_peak_i,
  input wire logic peak_max_i,
  input wire logic cs_latch_i,
  input wire logic supply_undervoltage_lockout_i,
  input wire logic vcc_on_i,
  input wire logic vcc_reset_i,
  input wire logic brown_out_input_i,
  // Drive and status
  output logic gate_o,
  output logic [6:0] freq_khz_o,
  output logic [9:0] setpoint_mv_o,
  output logic skip_o,
  output logic latched_o,
  output logic err_flag_o
);

  // Foldback curve: linear between the two feedback points
  function automatic logic [6:0] fold_freq(input logic [11:0] fb);
    logic [15:0] t;
    t = 16'(fb - `FLFC_FB_FOLD_LO) * `FLFC_F_SPAN / `FLFC_FOLD_WIDTH;
    if (fb >= `FLFC_FB_FOLD_HI) begin
      fold_freq = `FLFC_F_NOM;
    end else if (fb <= `FLFC_FB_FOLD_LO) begin
      fold_freq = `FLFC_F_MIN;
    end else begin
      fold_freq = 7'(`FLFC_F_MIN + t[6:0]);
    end
  endfunction

  // Peak setpoint: feedback divided by three, clamped at both ends
  function automatic logic [9:0] ipk_setpt(input logic [11:0] fb);
    if (fb >= `FLFC_FB_IPK_HI) begin
      ipk_setpt = `FLFC_IPK_MAX;
    end else if (fb <= `FLFC_FB_IPK_LO) begin
      ipk_setpt = `FLFC_IPK_MIN;
    end else begin
      ipk_setpt = 10'(fb / `FLFC_IPK_DIV);
    end
  endfunction

  flfc_pkg::flfc_state_t state_q; // Supervisor state
  flfc_pkg::flfc_state_t state_d;
  logic [1:0] ctrl_q; // Option and enable bits
  logic ack_q; // Bus answer
  logic [31:0] rdat_q; // Bus read data
  logic err_q; // Overload error flag
  logic arm_q; // Undervoltage latch check armed
  logic [23:0] tmr_q; // Fault timer
  logic tmr_exp; // Timer has run out
  logic [3:0] reg_cnt_q; // Cycles without a maximum peak
  logic peak_seen_q; // Maximum peak seen this cycle
  logic peak_hit_q; // Peak comparator ended this on time
  logic [2:0] cs_cnt_q; // Consecutive sense latch samples
  logic cs_trip; // Sense latch confirmed
  logic uv_q; // Delayed undervoltage level
  logic von_q; // Delayed turn-on level
  logic uv_ev; // Undervoltage onset
  logic von_ev; // Turn-on threshold reached
  logic restart; // Brown-out or supply reset request
  logic opt_latch; // Latched overcurrent option
  logic gate_q;
  logic [6:0] freq_q;
  logic [9:0] setpt_q;
  logic skip_q;
  logic osc_cyc; // Switching cycle start
  logic osc_on; // On-time window
  logic osc_late; // Late off-time sample point

  flfc_osc u_osc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .freq_khz_i(freq_q),
    .cyc_o(osc_cyc),
    .on_o(osc_on),
    .late_o(osc_late)
  );

  assign opt_latch = ctrl_q[`FLFC_CTRL_LATCH];
  assign uv_ev = supply_undervoltage_lockout_i && !uv_q;
  assign von_ev = vcc_on_i && !von_q;
  assign restart = brown_out_input_i || vcc_reset_i;
  assign tmr_exp = err_q && (tmr_q >= 24'(FAULT_CYCLES - 1));
  // More than four consecutive samples: the fifth confirms
  assign cs_trip = osc_late && cs_latch_i && !gate_q &&
                   (cs_cnt_q >= `FLFC_CS_CONSEC);

  // Wishbone: one wait state, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      unique case (wb_adr_i)
        `FLFC_ADR_CTRL: rdat_q <= {30'h00000000, ctrl_q};
        `FLFC_ADR_STAT: rdat_q <= {24'h000000, cs_cnt_q, arm_q,
                                   err_q, state_q};
        `FLFC_ADR_LOOP: rdat_q <= {5'h00, skip_q, setpt_q, 9'h000,
                                   freq_q};
        default: rdat_q <= 32'h00000000;
      endcase
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Control register write, taken on the acknowledging edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `FLFC_CTRL_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && ack_q &&
                 wb_sel_i[0] && wb_adr_i == `FLFC_ADR_CTRL) begin
      ctrl_q <= wb_dat_i[1:0];
    end
  end

  // Edge detectors on the supply comparators
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uv_q <= 1'b0;
      von_q <= 1'b0;
    end else begin
      uv_q <= supply_undervoltage_lockout_i;
      von_q <= vcc_on_i;
    end
  end

  // Loop settings follow feedback, registered for clean outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_q <= `FLFC_F_NOM;
      setpt_q <= `FLFC_IPK_MAX;
      skip_q <= 1'b0;
    end else begin
      freq_q <= fold_freq(fb_mv_i);
      setpt_q <= ipk_setpt(fb_mv_i);
      skip_q <= (fb_mv_i < `FLFC_FB_SKIP);
    end
  end

  // Supervisor; restart requests outrank everything
  always_comb begin
    state_d = state_q;
    if (restart) begin
      state_d = flfc_pkg::FLFC_START;
    end else begin
      unique case (state_q)
        flfc_pkg::FLFC_START: begin
          if (von_ev && ctrl_q[`FLFC_CTRL_EN]) begin
            state_d = flfc_pkg::FLFC_RUN;
          end
        end
        flfc_pkg::FLFC_RUN: begin
          if (cs_trip) begin
            state_d = flfc_pkg::FLFC_LATCH;
          end else if (uv_ev) begin
            // Pre-short: undervoltage while flagged and armed
            if (opt_latch && arm_q && err_q) begin
              state_d = flfc_pkg::FLFC_LATCH;
            end else begin
              state_d = flfc_pkg::FLFC_HIC1;
            end
          end else if (tmr_exp) begin
            if (opt_latch) begin
              state_d = flfc_pkg::FLFC_LATCH;
            end else begin
              state_d = flfc_pkg::FLFC_HIC1;
            end
          end
        end
        flfc_pkg::FLFC_HIC1: begin
          // First turn-on is ignored
          if (von_ev) begin
            state_d = flfc_pkg::FLFC_HIC2;
          end
        end
        flfc_pkg::FLFC_HIC2: begin
          if (von_ev) begin
            state_d = flfc_pkg::FLFC_RUN;
          end
        end
        flfc_pkg::FLFC_LATCH: begin
          state_d = flfc_pkg::FLFC_LATCH;
        end
        default: state_d = flfc_pkg::FLFC_START;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= flfc_pkg::FLFC_START;
    end else begin
      state_q <= state_d;
    end
  end

  // Undervoltage latch check arming
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_q <= 1'b1;
    end else if (state_q == flfc_pkg::FLFC_START ||
                 state_q == flfc_pkg::FLFC_HIC1 ||
                 state_q == flfc_pkg::FLFC_HIC2) begin
      arm_q <= opt_latch;
    end else if (err_q && state_q == flfc_pkg::FLFC_RUN && osc_cyc &&
                 !peak_max_i && !peak_seen_q &&
                 reg_cnt_q == `FLFC_REG_CYCLES - 4'h1) begin
      // A peak in the same cycle keeps the flag, so stay armed too
      arm_q <= 1'b0;
    end
  end

  // Peak bookkeeping per switching cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peak_seen_q <= 1'b0;
      peak_hit_q <= 1'b0;
    end else if (osc_cyc) begin
      peak_seen_q <= 1'b0;
      peak_hit_q <= 1'b0;
    end else begin
      peak_seen_q <= peak_seen_q || peak_max_i;
      peak_hit_q <= peak_hit_q || (gate_q && cs_peak_i);
    end
  end

  // Error flag: set wins over the regulation clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
      reg_cnt_q <= 4'h0;
    end else if (state_q != flfc_pkg::FLFC_RUN) begin
      err_q <= 1'b0;
      reg_cnt_q <= 4'h0;
    end else if (peak_max_i) begin
      err_q <= 1'b1;
      reg_cnt_q <= 4'h0;
    end else if (osc_cyc) begin
      if (peak_seen_q) begin
        reg_cnt_q <= 4'h0;
      end else if (reg_cnt_q == `FLFC_REG_CYCLES - 4'h1) begin
        // Regulation reached: release the flag
        err_q <= 1'b0;
        reg_cnt_q <= 4'h0;
      end else begin
        reg_cnt_q <= reg_cnt_q + 4'h1;
      end
    end
  end

  // Fault timer counts only while the flag stands
  always_ff @(posedge clk_i) begin
    if (rst_i || !err_q || state_q != flfc_pkg::FLFC_RUN) begin
      tmr_q <= 24'h000000;
    end else if (!tmr_exp) begin
      tmr_q <= tmr_q + 24'h000001;
    end
  end

  // Off-time sense latch counter, one sample per cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != flfc_pkg::FLFC_RUN) begin
      cs_cnt_q <= 3'h0;
    end else if (osc_late && !gate_q) begin
      if (!cs_latch_i) begin
        cs_cnt_q <= 3'h0;
      end else if (!cs_trip) begin
        cs_cnt_q <= cs_cnt_q + 3'h1;
      end
    end
  end

  // Gate drive: stops in the same cycle the state leaves run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= osc_on && !osc_cyc && !peak_hit_q && !cs_peak_i &&
                !skip_q && state_d == flfc_pkg::FLFC_RUN;
    end
  end

  assign gate_o = gate_q;
  assign freq_khz_o = freq_q;
  assign setpoint_mv_o = setpt_q;
  assign skip_o = skip_q;
  assign latched_o = (state_q == flfc_pkg::FLFC_LATCH);
  assign err_flag_o = err_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_timer_latch: assert property (
    state_q == flfc_pkg::FLFC_RUN && tmr_exp && opt_latch && !restart
    && !uv_ev |=> state_q == flfc_pkg::FLFC_LATCH)
    else $error("timer expiry did not latch");
  chk_latch_gate: assert property (
    state_q == flfc_pkg::FLFC_LATCH |-> !gate_o [*2])
    else $error("gate active while latched");
  chk_latch_hold: assert property (
    state_q == flfc_pkg::FLFC_LATCH && !restart
    |=> state_q == flfc_pkg::FLFC_LATCH)
    else $error("latch left without reset");
  chk_preshort_latch: assert property (
    state_q == flfc_pkg::FLFC_RUN && uv_ev && opt_latch && arm_q &&
    err_q && !restart && !cs_trip |=> latched_o)
    else $error("pre-short did not latch");
  chk_supply_undervoltage_lockout_hiccup: assert property (
    state_q == flfc_pkg::FLFC_RUN && uv_ev && !err_q && !restart &&
    !cs_trip |=> state_q == flfc_pkg::FLFC_HIC1)
    else $error("undervoltage without flag did not hiccup");
  chk_disarm_reg: assert property (
    $fell(err_q) && $past(state_q) == flfc_pkg::FLFC_RUN &&
    state_q == flfc_pkg::FLFC_RUN |-> !arm_q)
    else $error("check still armed after regulation");
  chk_fold_min: assert property (
    fb_mv_i <= `FLFC_FB_FOLD_LO |=> freq_khz_o == `FLFC_F_MIN)
    else $error("frequency below minimum");
  chk_setpt_floor: assert property (
    fb_mv_i <= `FLFC_FB_IPK_LO |=> setpoint_mv_o == `FLFC_IPK_MIN)
    else $error("setpoint not frozen");
  chk_skip_gate: assert property (
    skip_q |=> !gate_o)
    else $error("gate pulse during skip");
  chk_cs_trip: assert property (
    state_q == flfc_pkg::FLFC_RUN && cs_trip && !restart
    |=> latched_o)
    else $error("sense fault did not latch");
  chk_cs_clear: assert property (
    osc_late && !gate_q && !cs_latch_i && state_q ==
    flfc_pkg::FLFC_RUN |=> cs_cnt_q == 3'h0)
    else $error("sense counter not cleared");

  cov_latch: cover property (latched_o);
  cov_hiccup: cover property (state_q == flfc_pkg::FLFC_HIC2 ##1
    state_q == flfc_pkg::FLFC_RUN);
  cov_skip: cover property (skip_q && state_q == flfc_pkg::FLFC_RUN);

endmodule
`default_nettype wire
